// ==== mapc_pkg.sv ====
// Constants and types for the region attribute and permission checker
package mapc_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] REGION_SEL_OFS = 8'h04;
    localparam logic [7:0] REGION_ATTR_OFS = 8'h08;
    localparam logic [7:0] FAULT_STAT_OFS = 8'h0C;
    localparam logic [7:0] FAULT_ADDR_OFS = 8'h10;
    localparam logic [7:0] LAST_CHECK_OFS = 8'h14;

    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_BACKGROUND_BIT = 1;

    // Region attribute register fields
    localparam int ATTR_ENABLE_BIT = 0;
    localparam int ATTR_BUFFERABLE_BIT = 16;
    localparam int ATTR_CACHEABLE_BIT = 17;
    localparam int ATTR_SHAREABLE_BIT = 18;
    localparam int ATTR_TEX_LSB = 19;
    localparam int ATTR_AP_LSB = 24;
    localparam int ATTR_XN_BIT = 28;

    // Fault status fields
    localparam int FSTAT_FETCH_VIOL_BIT = 0;
    localparam int FSTAT_DATA_VIOL_BIT = 1;
    localparam int FSTAT_ADDR_VALID_BIT = 7;

    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] ATTR_RESET = 32'h0000_0000;
    localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;

    // Access permission codes
    localparam logic [2:0] AP_NONE = 3'h0;
    localparam logic [2:0] AP_PRIV_RW = 3'h1;
    localparam logic [2:0] AP_USER_RO = 3'h2;
    localparam logic [2:0] AP_FULL = 3'h3;
    localparam logic [2:0] AP_RESERVED = 3'h4;
    localparam logic [2:0] AP_PRIV_RO = 3'h5;
    localparam logic [2:0] AP_RO_A = 3'h6;
    localparam logic [2:0] AP_RO_B = 3'h7;

    // Cache policy codes
    localparam logic [1:0] POL_NONCACHE = 2'h0;
    localparam logic [1:0] POL_WB_RWALLOC = 2'h1;
    localparam logic [1:0] POL_WT_NOALLOC = 2'h2;
    localparam logic [1:0] POL_WB_NOALLOC = 2'h3;

    typedef enum logic [1:0] {
        MEM_STRONG = 2'h0,
        MEM_DEVICE = 2'h1,
        MEM_NORMAL = 2'h2,
        MEM_RESERVED = 2'h3
    } mapc_mem_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WR = 2'b01,
        BUS_RWAIT = 2'b11,
        BUS_RDONE = 2'b10
    } mapc_bus_t;

endpackage

// ==== mapc_top.sv ====
// Region attribute decoder, permission checker and register slave
//
// Summary of operation
// [R1] Decode attributes, fault on missing permission
// [R2] Permission 000 faults every access
// [R3] Permission 001: privileged only, read/write
// [R4] Permission 010: unprivileged writes fault
// [R5] 011 full access; 100 reserved
// [R6] Permission 101: privileged reads only
// [R7] Permission 110/111: reads only, any level
// [R8] Type 000, uncached: strongly ordered/device, shareable
// [R9] Don't-care bits ignored in decode
// [R10] Type 000 cached: normal, through/back policy
// [R11] Type 001: non-cacheable or write-back, rest reserved
// [R12] Type 010: only uncached unbuffered is device
// [R13] Type 1xx: outer from type, inner from C/B
// [R14] Policy codes: none, WB-alloc, WT, WB
// [R15] Decoded attributes never alter access checking
// [R16] Software programs recommended region settings
// [R17] Violation raises fault and records cause
// [R18] Highest numbered matching region wins
// [R19] No match: background only for privileged
// [R20] Execute-never region faults instruction fetches
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module mapc_top #(
    parameter int NUM_REGIONS = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // AHB-Lite register slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // Access request from the core
    input wire logic i_acc_valid,
    input wire logic [31:0] i_acc_addr,
    input wire logic i_acc_write,
    input wire logic i_acc_priv,
    input wire logic i_acc_fetch,
    input wire logic [NUM_REGIONS-1:0] i_region_hit,
    // Check result, one cycle after the request
    output logic o_chk_valid,
    output logic o_chk_fault,
    output logic o_chk_background,
    output logic [2:0] o_chk_region,
    output logic [1:0] o_mem_type,
    output logic o_shareable,
    output logic [1:0] o_inner_policy,
    output logic [1:0] o_outer_policy,
    output logic o_memmanage_fault
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [31:0] ctrl_q;
    logic [2:0] region_sel_q;
    logic [31:0] attr_q [NUM_REGIONS];
    logic [7:0] memmanage_fault_status_q;
    logic [31:0] fault_addr_q;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero-wait writes, one wait state on reads

    mapc_pkg::mapc_bus_t bus_q;
    logic [7:0] addr_q;
    logic addr_phase;
    logic wr_en;
    logic [31:0] rd_data;

    assign addr_phase = i_hsel && i_hready && i_htrans[1];
    assign o_hreadyout = (bus_q != mapc_pkg::BUS_RWAIT);
    assign o_hresp = 1'b0;
    assign wr_en = (bus_q == mapc_pkg::BUS_WR);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_q <= mapc_pkg::BUS_IDLE;
            addr_q <= 8'h00;
        end else begin
            unique case (bus_q)
                mapc_pkg::BUS_RWAIT: begin
                    bus_q <= mapc_pkg::BUS_RDONE;
                end
                default: begin
                    if (addr_phase) begin
                        addr_q <= {i_haddr[7:2], 2'b00};
                        bus_q <= i_hwrite ? mapc_pkg::BUS_WR : mapc_pkg::BUS_RWAIT;
                    end else begin
                        bus_q <= mapc_pkg::BUS_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Check pipeline registers (declared here for readback)

    logic chk_valid_q;
    logic chk_fault_q;
    logic chk_bg_q;
    logic [2:0] chk_region_q;
    logic [1:0] mem_type_q;
    logic share_q;
    logic [1:0] inner_q;
    logic [1:0] outer_q;

    // Read mux, loaded during the wait state
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (addr_q)
            mapc_pkg::CTRL_OFS: rd_data = ctrl_q;
            mapc_pkg::REGION_SEL_OFS: rd_data = {29'h0000_0000, region_sel_q};
            mapc_pkg::REGION_ATTR_OFS: rd_data = attr_q[region_sel_q];
            mapc_pkg::FAULT_STAT_OFS: rd_data = {24'h00_0000, memmanage_fault_status_q};
            mapc_pkg::FAULT_ADDR_OFS: rd_data = fault_addr_q;
            mapc_pkg::LAST_CHECK_OFS: begin
                rd_data = {20'h0_0000, chk_bg_q, chk_region_q, mem_type_q, share_q,
                           inner_q, outer_q, chk_fault_q};
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_hrdata <= 32'h0000_0000;
        end else if (bus_q == mapc_pkg::BUS_RWAIT) begin
            o_hrdata <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q <= mapc_pkg::CTRL_RESET;
            region_sel_q <= 3'h0;
        end else if (wr_en) begin
            if (addr_q == mapc_pkg::CTRL_OFS) begin
                ctrl_q <= {30'h0000_0000, i_hwdata[1:0]};
            end
            if (addr_q == mapc_pkg::REGION_SEL_OFS) begin
                region_sel_q <= i_hwdata[2:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                attr_q[i] <= mapc_pkg::ATTR_RESET;
            end
        end else if (wr_en && addr_q == mapc_pkg::REGION_ATTR_OFS) begin
            attr_q[region_sel_q] <= i_hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Region selection

    logic mpu_on;
    logic bg_on;
    logic any_hit;
    logic [2:0] win_idx;
    logic [31:0] win_attr;

    assign mpu_on = ctrl_q[mapc_pkg::CTRL_ENABLE_BIT];
    assign bg_on = ctrl_q[mapc_pkg::CTRL_BACKGROUND_BIT];

    always_comb begin
        any_hit = 1'b0;
        win_idx = 3'h0;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            if (i_region_hit[i] && attr_q[i][mapc_pkg::ATTR_ENABLE_BIT]) begin
                any_hit = 1'b1;
                win_idx = 3'(i); // R18
            end
        end
        win_attr = attr_q[win_idx];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Attribute decode

    logic [2:0] type_extension_field;
    logic sh_bit;
    logic c_bit;
    logic b_bit;
    logic [2:0] ap;
    logic xn;
    mapc_pkg::mapc_mem_t dec_type;
    logic dec_share;
    logic [1:0] dec_inner;
    logic [1:0] dec_outer;

    assign type_extension_field = win_attr[mapc_pkg::ATTR_TEX_LSB +: 3];
    assign sh_bit = win_attr[mapc_pkg::ATTR_SHAREABLE_BIT];
    assign c_bit = win_attr[mapc_pkg::ATTR_CACHEABLE_BIT];
    assign b_bit = win_attr[mapc_pkg::ATTR_BUFFERABLE_BIT];
    assign ap = win_attr[mapc_pkg::ATTR_AP_LSB +: 3];
    assign xn = win_attr[mapc_pkg::ATTR_XN_BIT];

    // Attributes are exported only; they never feed the permission check
    always_comb begin // R1
        dec_type = mapc_pkg::MEM_RESERVED;
        dec_share = 1'b0;
        dec_inner = mapc_pkg::POL_NONCACHE;
        dec_outer = mapc_pkg::POL_NONCACHE;
        if (type_extension_field[2]) begin
            dec_type = mapc_pkg::MEM_NORMAL; // R13
            dec_share = sh_bit;
            dec_outer = type_extension_field[1:0]; // R14
            dec_inner = {c_bit, b_bit}; // R14
        end else begin
            unique case (type_extension_field[1:0])
                2'h0: begin
                    if (!c_bit) begin
                        // Shareable bit unused here
                        dec_type = b_bit ? mapc_pkg::MEM_DEVICE : mapc_pkg::MEM_STRONG; // R8 R9
                        dec_share = 1'b1; // R8
                    end else begin
                        dec_type = mapc_pkg::MEM_NORMAL; // R10
                        dec_share = sh_bit;
                        dec_inner = b_bit ? mapc_pkg::POL_WB_RWALLOC
                                          : mapc_pkg::POL_WT_NOALLOC; // R10
                        dec_outer = dec_inner;
                    end
                end
                2'h1: begin
                    if (!c_bit && !b_bit) begin
                        dec_type = mapc_pkg::MEM_NORMAL; // R11
                        dec_share = sh_bit;
                    end else if (c_bit && b_bit) begin
                        dec_type = mapc_pkg::MEM_NORMAL; // R11
                        dec_share = sh_bit;
                        dec_inner = mapc_pkg::POL_WB_RWALLOC;
                        dec_outer = mapc_pkg::POL_WB_RWALLOC;
                    end
                end
                2'h2: begin
                    if (!c_bit && !b_bit) begin
                        dec_type = mapc_pkg::MEM_DEVICE; // R12 R9
                    end
                end
                default: begin
                    dec_type = mapc_pkg::MEM_RESERVED;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Permission check

    logic ap_fault;
    logic acc_fault;
    logic use_bg;

    always_comb begin
        unique case (ap)
            mapc_pkg::AP_NONE: ap_fault = 1'b1; // R2
            mapc_pkg::AP_PRIV_RW: ap_fault = !i_acc_priv; // R3
            mapc_pkg::AP_USER_RO: ap_fault = !i_acc_priv && i_acc_write; // R4
            mapc_pkg::AP_FULL: ap_fault = 1'b0; // R5
            mapc_pkg::AP_RESERVED: ap_fault = 1'b1; // R5
            mapc_pkg::AP_PRIV_RO: ap_fault = !i_acc_priv || i_acc_write; // R6
            mapc_pkg::AP_RO_A,
            mapc_pkg::AP_RO_B: ap_fault = i_acc_write; // R7
            default: ap_fault = 1'b1;
        endcase
    end

    assign use_bg = mpu_on && !any_hit;

    always_comb begin
        if (!mpu_on) begin
            acc_fault = 1'b0;
        end else if (!any_hit) begin
            acc_fault = !(bg_on && i_acc_priv); // R19
        end else begin
            acc_fault = ap_fault || (xn && i_acc_fetch); // R1 R20
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Check result registers

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            chk_valid_q <= 1'b0;
            chk_fault_q <= 1'b0;
            chk_bg_q <= 1'b0;
            chk_region_q <= 3'h0;
            mem_type_q <= mapc_pkg::MEM_STRONG;
            share_q <= 1'b0;
            inner_q <= mapc_pkg::POL_NONCACHE;
            outer_q <= mapc_pkg::POL_NONCACHE;
        end else begin
            chk_valid_q <= i_acc_valid;
            if (i_acc_valid) begin
                chk_fault_q <= acc_fault;
                chk_bg_q <= use_bg || !mpu_on;
                chk_region_q <= win_idx;
                // Background and disabled map read as normal non-cacheable
                mem_type_q <= (use_bg || !mpu_on) ? mapc_pkg::MEM_NORMAL : dec_type;
                share_q <= (use_bg || !mpu_on) ? 1'b0 : dec_share;
                inner_q <= (use_bg || !mpu_on) ? mapc_pkg::POL_NONCACHE : dec_inner;
                outer_q <= (use_bg || !mpu_on) ? mapc_pkg::POL_NONCACHE : dec_outer;
            end
        end
    end

    assign o_chk_valid = chk_valid_q;
    assign o_chk_fault = chk_valid_q && chk_fault_q;
    assign o_memmanage_fault = chk_valid_q && chk_fault_q; // R17
    assign o_chk_background = chk_bg_q;
    assign o_chk_region = chk_region_q;
    assign o_mem_type = mem_type_q;
    assign o_shareable = share_q; // R15
    assign o_inner_policy = inner_q;
    assign o_outer_policy = outer_q;

    ////////////////////////////////////////////////////////////////////////////
    // Fault cause recording, write one to clear, set wins

    logic new_fault;
    logic [7:0] fstat_set;
    logic [7:0] fstat_clr;

    assign new_fault = i_acc_valid && acc_fault;

    always_comb begin
        fstat_set = 8'h00;
        fstat_set[mapc_pkg::FSTAT_FETCH_VIOL_BIT] = new_fault && i_acc_fetch;
        fstat_set[mapc_pkg::FSTAT_DATA_VIOL_BIT] = new_fault && !i_acc_fetch;
        fstat_set[mapc_pkg::FSTAT_ADDR_VALID_BIT] = new_fault && !i_acc_fetch;
        fstat_clr = (wr_en && addr_q == mapc_pkg::FAULT_STAT_OFS) ? i_hwdata[7:0] : 8'h00;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            memmanage_fault_status_q <= 8'h00;
        end else begin
            memmanage_fault_status_q <= (memmanage_fault_status_q & ~fstat_clr)
                                        | fstat_set; // R17
        end
    end

    // Data fault address held until its valid flag is cleared
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fault_addr_q <= mapc_pkg::FAULT_ADDR_RESET;
        end else if (fstat_set[mapc_pkg::FSTAT_ADDR_VALID_BIT]
                     && (!memmanage_fault_status_q[mapc_pkg::FSTAT_ADDR_VALID_BIT]
                         || fstat_clr[mapc_pkg::FSTAT_ADDR_VALID_BIT])) begin
            fault_addr_q <= i_acc_addr; // R17
        end else if (wr_en && addr_q == mapc_pkg::FAULT_ADDR_OFS) begin
            fault_addr_q <= i_hwdata;
        end
    end

endmodule

// ==== mapc_top_asserts.sv ====
// Port-level concurrent checks for the attribute and permission checker
`timescale 1ns/100ps
module mapc_top_asserts #(
    parameter int NUM_REGIONS = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Register bus
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // Access request
    input wire logic i_acc_valid,
    input wire logic [NUM_REGIONS-1:0] i_region_hit,
    // Check result
    input wire logic o_chk_valid,
    input wire logic o_chk_fault,
    input wire logic o_chk_background,
    input wire logic [1:0] o_mem_type,
    input wire logic o_shareable,
    input wire logic [1:0] o_inner_policy,
    input wire logic [1:0] o_outer_policy,
    input wire logic o_memmanage_fault
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    ////////////////////////////////////////////////////////////////////////////////
    sequence rd_taken;
        i_hsel && i_hready && i_htrans[1] && !i_hwrite;
    endsequence
    sequence wr_taken;
        i_hsel && i_hready && i_htrans[1] && i_hwrite;
    endsequence
    sequence one_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    a_valid_next: assert property (i_acc_valid |=> o_chk_valid)
        else $error("check result missing one cycle after access");
    a_no_spurious: assert property (!i_acc_valid |=> !o_chk_valid && !o_chk_fault)
        else $error("check result without access");
    a_fault_exception: assert property (o_chk_fault == o_memmanage_fault)
        else $error("fault exception differs from check fault");
    a_nohit_background: assert property (i_acc_valid && i_region_hit == '0 |=> o_chk_background)
        else $error("access with no hit did not use background");
    a_bg_default_attr: assert property (o_chk_valid && o_chk_background |->
        o_mem_type == mapc_pkg::MEM_NORMAL && !o_shareable && o_inner_policy == 2'h0
        && o_outer_policy == 2'h0)
        else $error("background attributes wrong");
    a_attr_hold: assert property (!i_acc_valid |=>
        $stable({o_mem_type, o_shareable, o_inner_policy, o_outer_policy}))
        else $error("attributes changed without access");
    a_strong_share: assert property (o_chk_valid && o_mem_type == mapc_pkg::MEM_STRONG
        |-> o_shareable)
        else $error("strongly ordered not shareable");
    a_read_wait: assert property (rd_taken |=> one_wait)
        else $error("read data phase not one wait state");
    a_write_nowait: assert property (wr_taken |=> o_hreadyout)
        else $error("write data phase stalled");
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("bus response not okay");
endmodule

bind mapc_top mapc_top_asserts #(.NUM_REGIONS(NUM_REGIONS)) mapc_top_asserts_i (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_acc_valid(i_acc_valid), .i_region_hit(i_region_hit), .o_chk_valid(o_chk_valid),
    .o_chk_fault(o_chk_fault), .o_chk_background(o_chk_background), .o_mem_type(o_mem_type),
    .o_shareable(o_shareable), .o_inner_policy(o_inner_policy),
    .o_outer_policy(o_outer_policy), .o_memmanage_fault(o_memmanage_fault));

// ==== mapc_core_model.sv ====
// Core load/store and fetch model issuing single-cycle access requests
`timescale 1ns/100ps
module mapc_core_model (
    // Clock
    input wire logic i_ref_clk,
    // Check result
    input wire logic i_chk_valid,
    input wire logic i_chk_fault,
    // Access request
    output logic o_acc_valid,
    output logic [31:0] o_acc_addr,
    output logic o_acc_write,
    output logic o_acc_priv,
    output logic o_acc_fetch,
    output logic [7:0] o_region_hit
);
    initial begin
        o_acc_valid = 1'b0;
        o_acc_addr = 32'h0;
        {o_acc_write, o_acc_priv, o_acc_fetch} = 3'h0;
        o_region_hit = 8'h0;
    end

    // Gap gives slow issue; idle fields are scrambled, not held
    task automatic issue(input int gap, input logic [31:0] a, input logic wr, pr, fe,
                         input logic [7:0] hit, output logic v, f);
        repeat (gap + 1) @(posedge i_ref_clk);
        o_acc_valid <= 1'b1;
        o_acc_addr <= a;
        {o_acc_write, o_acc_priv, o_acc_fetch} <= {wr, pr, fe};
        o_region_hit <= hit;
        @(posedge i_ref_clk);
        o_acc_valid <= 1'b0;
        o_acc_addr <= ~a;
        {o_acc_write, o_acc_priv, o_acc_fetch} <= ~{wr, pr, fe};
        o_region_hit <= ~hit;
        @(negedge i_ref_clk);
        v = i_chk_valid;
        f = i_chk_fault;
    endtask
endmodule

// ==== mapc_top_test.sv ====
// Self-checking bench for the attribute decoder and permission checker
`timescale 1ns/100ps
module mapc_top_test;
    logic i_ref_clk, i_nrst, i_hsel, i_hwrite;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rdata, i_acc_addr;
    logic [1:0] i_htrans, o_mem_type, o_inner_policy, o_outer_policy;
    logic o_hreadyout, o_hresp, i_acc_valid, i_acc_write, i_acc_priv, i_acc_fetch;
    logic o_chk_valid, o_chk_fault, o_chk_background, o_shareable, o_memmanage_fault;
    logic [7:0] i_region_hit;
    logic [2:0] o_chk_region;
    logic flt, vld;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    typedef struct packed {
        logic [2:0] type_extension_field;
        logic s, c, b;
        logic [1:0] ty;
        logic sh, pol;
        logic [1:0] inn, outr;
    } mapc_row_t;
    // Packed rows: tex, s, c, b, type, share, policy valid, inner, outer
    mapc_row_t rows [12] = '{14'h0020, 14'h0160, 14'h029A, 14'h07B5, 14'h0CB0, 14'h0B95,
        14'h09C0, 14'h1440, 14'h13C0, 14'h35B6, 14'h3A9B, 14'h239C};

    mapc_top #(.NUM_REGIONS(8)) mapc_top_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
        .i_acc_valid(i_acc_valid), .i_acc_addr(i_acc_addr), .i_acc_write(i_acc_write),
        .i_acc_priv(i_acc_priv), .i_acc_fetch(i_acc_fetch), .i_region_hit(i_region_hit),
        .o_chk_valid(o_chk_valid), .o_chk_fault(o_chk_fault),
        .o_chk_background(o_chk_background), .o_chk_region(o_chk_region),
        .o_mem_type(o_mem_type), .o_shareable(o_shareable), .o_inner_policy(o_inner_policy),
        .o_outer_policy(o_outer_policy), .o_memmanage_fault(o_memmanage_fault));
    mapc_core_model mapc_core_model_i (.i_ref_clk(i_ref_clk), .i_chk_valid(o_chk_valid),
        .i_chk_fault(o_chk_fault), .o_acc_valid(i_acc_valid), .o_acc_addr(i_acc_addr),
        .o_acc_write(i_acc_write), .o_acc_priv(i_acc_priv), .o_acc_fetch(i_acc_fetch),
        .o_region_hit(i_region_hit));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_rdy;
        do @(negedge i_ref_clk); while (o_hreadyout !== 1'b1);
        rdata = o_hrdata;
        @(posedge i_ref_clk);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_ref_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= {24'h0, a};
        i_hwrite <= wr;
        wait_rdy();
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        wait_rdy();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        check(nm, rdata, e);
    endtask
    task automatic set_region(input logic [2:0] idx, ap, type_extension_field, input logic s, c, b, xn);
        bus(1'b1, mapc_pkg::REGION_SEL_OFS, {29'h0, idx});
        bus(1'b1, mapc_pkg::REGION_ATTR_OFS, {3'h0, xn, 1'h0, ap, 2'h0, type_extension_field, s, c, b, 16'h1});
    endtask
    task automatic acc(input logic [31:0] a, input logic wr, pr, fe, input logic [7:0] hit);
        mapc_core_model_i.issue(total_checks % 3, a, wr, pr, fe, hit, vld, flt);
        check("chk_valid", vld, 1'b1);
        check("exception", o_memmanage_fault, flt);
    endtask
    function automatic logic perm_fault(input logic [2:0] ap, input logic pr, wr);
        case (ap)
            3'h1: return !pr;
            3'h2: return !pr && wr;
            3'h3: return 1'b0;
            3'h5: return !pr || wr;
            3'h6, 3'h7: return wr;
            default: return 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc >= 5000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        i_nrst = 1'b0;
        i_hsel = 1'b0;
        i_haddr = 32'h0;
        i_htrans = 2'h0;
        i_hwrite = 1'b0;
        i_hwdata = 32'h0;
        repeat (3) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        bus(1'b1, mapc_pkg::CTRL_OFS, 32'h1);
        for (int ap = 0; ap < 8; ap++) begin
            set_region(3'h5, 3'(ap), 3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
            for (int k = 0; k < 4; k++) begin
                acc(32'h0000_0100, k[0], k[1], 1'b0, 8'h20);
                check("perm", flt, perm_fault(3'(ap), k[1], k[0]));
            end
        end
        for (int i = 0; i < 12; i++) begin
            set_region(3'h3, mapc_pkg::AP_FULL, rows[i].type_extension_field, rows[i].s, rows[i].c, rows[i].b, 1'b0);
            acc(32'h0000_1000, 1'b0, 1'b1, 1'b0, 8'h08);
            check("mem_type", o_mem_type, rows[i].ty);
            if (rows[i].ty != 2'h3) check("share", o_shareable, rows[i].sh);
            if (rows[i].pol) begin
                check("inner", o_inner_policy, rows[i].inn);
                check("outer", o_outer_policy, rows[i].outr);
            end
            check("attr_fault", flt, 1'b0);
        end
        // Fault cause and address capture, then clear
        bus(1'b1, mapc_pkg::FAULT_STAT_OFS, 32'hFFFF_FFFF);
        set_region(3'h2, mapc_pkg::AP_USER_RO, 3'h0, 1'b1, 1'b0, 1'b1, 1'b1);
        acc(32'h2000_0040, 1'b1, 1'b0, 1'b0, 8'h04);
        check("user_write", flt, 1'b1);
        acc(32'h2000_0080, 1'b1, 1'b0, 1'b0, 8'h04);
        rd(mapc_pkg::FAULT_STAT_OFS, 32'h0000_0082, "fault_stat");
        rd(mapc_pkg::FAULT_ADDR_OFS, 32'h2000_0040, "fault_addr");
        bus(1'b1, mapc_pkg::FAULT_STAT_OFS, 32'hFFFF_FFFF);
        rd(mapc_pkg::FAULT_STAT_OFS, 32'h0, "stat_clear");
        acc(32'h2000_0000, 1'b0, 1'b1, 1'b1, 8'h04);
        check("xn_fetch", flt, 1'b1);
        rd(mapc_pkg::FAULT_STAT_OFS, 32'h0000_0001, "fetch_stat");
        // Overlap: higher region forbids the write
        set_region(3'h6, mapc_pkg::AP_RO_A, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0);
        acc(32'h2000_0000, 1'b1, 1'b1, 1'b0, 8'h44);
        check("win_fault", flt, 1'b1);
        check("win_region", o_chk_region, 3'h6);
        rd(mapc_pkg::LAST_CHECK_OFS, 32'h0000_06B5, "last_check");
        bus(1'b1, mapc_pkg::CTRL_OFS, 32'h3);
        acc(32'h4000_0000, 1'b0, 1'b1, 1'b0, 8'h00);
        check("bg_priv", {o_chk_background, flt}, 2'h2);
        acc(32'h4000_0000, 1'b0, 1'b0, 1'b0, 8'h00);
        check("bg_user", flt, 1'b1);
        bus(1'b1, mapc_pkg::CTRL_OFS, 32'h1);
        acc(32'h4000_0000, 1'b0, 1'b1, 1'b0, 8'h00);
        check("bg_off", flt, 1'b1);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0, "unmapped");
        // Reset in mid-run
        @(posedge i_ref_clk);
        i_nrst <= 1'b0;
        @(negedge i_ref_clk);
        check("rst_ready", o_hreadyout, 1'b1);
        check("rst_valid", o_chk_valid, 1'b0);
        @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        rd(mapc_pkg::CTRL_OFS, mapc_pkg::CTRL_RESET, "ctrl_rst");
        rd(mapc_pkg::REGION_ATTR_OFS, mapc_pkg::ATTR_RESET, "attr_rst");
        acc(32'h0, 1'b1, 1'b0, 1'b0, 8'hFF);
        check("mpu_off", {o_chk_background, flt}, 2'h2);
        wrap_up();
    end
endmodule
